// *** lpr_pkg.sv ***
// shared constants, types and timing for the refresh / power-down link
package lpr_pkg;
    // clock and widths
    localparam int CLK_MHZ = 250;
    localparam int CLK_PS = 1000000 / CLK_MHZ;
    localparam int NBANK = 4;
    localparam int BA_W = 2;
    localparam int ROW_W = 13;
    localparam int AP_BIT = 10;
    localparam int WT_W = 17;

    // timing figures, least times unless noted
    localparam int T_INIT_US = 200;
    localparam int T_RP_NS = 30;
    localparam int T_RFC_NS = 110;
    localparam int T_RCD_NS = 30;
    localparam int T_WR_NS = 15;
    localparam int T_MRD_NS = 10;
    localparam int T_CKE_NS = 10;
    localparam int T_PDEX_NS = 10;
    localparam int T_XSR_NS = 120;
    localparam int T_REFI_NS = 7000;  // longest spacing of refreshes

    // least time, rounded up, never below one cycle
    function automatic int ns_up(input int ns);
        int c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // longest time, rounded down, never below one cycle
    function automatic int ns_dn(input int ns);
        int c;
        c = (ns * 1000) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // cut a cycle count to the wait counter width
    function automatic logic [WT_W-1:0] cyc(input int c);
        return c[WT_W-1:0];
    endfunction

    localparam int INIT_CYC = T_INIT_US * CLK_MHZ;
    localparam int RP_CYC = ns_up(T_RP_NS);
    localparam int RFC_CYC = ns_up(T_RFC_NS);
    localparam int RCD_CYC = ns_up(T_RCD_NS);
    localparam int WR_CYC = ns_up(T_WR_NS);
    localparam int MRD_CYC = ns_up(T_MRD_NS);
    localparam int CKE_CYC = ns_up(T_CKE_NS);
    localparam int PDEX_CYC = ns_up(T_PDEX_NS);
    localparam int XSR_CYC = ns_up(T_XSR_NS);
    localparam int REFI_CYC = ns_dn(T_REFI_NS);

    // command codes as {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [BA_W-1:0] BA_MR = 2'h0;
    localparam logic [BA_W-1:0] BA_EMR = 2'h2;

    typedef enum logic [1:0] {OP_ACT, OP_PRE, OP_WRAP} lpr_op_t;
    typedef enum logic [2:0] {DS_IDLE, DS_ACTIVE, DS_AREF, DS_SREF, DS_PDN} lpr_dev_st_t;
    typedef enum logic [3:0] {
        CS_PWR, CS_IPRE, CS_IREF, CS_IMRS, CS_IEMRS, CS_IDLE,
        CS_SREF, CS_SRX, CS_PDN, CS_CSTOP, CS_CSX
    } lpr_ctl_st_t;
endpackage

// *** lpr_if.sv ***
// command, clock-enable and clock pins between controller and memory
`timescale 1ns/100ps
interface lpr_if import lpr_pkg::*;;
    logic ck;
    logic ck_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BA_W-1:0] ba;
    logic [ROW_W-1:0] addr;

    modport ctrl (output ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr);
    modport mem (input ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface

// *** lpr_mem.sv ***
// memory end: refresh, self refresh, power-down and mode register state
`timescale 1ns/100ps
module lpr_mem import lpr_pkg::*; (
    input wire logic clk,
    input wire logic resetn,
    lpr_if.mem bus,
    output lpr_dev_st_t state_r,
    output logic [ROW_W-1:0] ref_row_r,
    output logic [ROW_W-1:0] mode_r,
    output logic [ROW_W-1:0] emode_r,
    output logic modes_set_r,
    output logic [NBANK-1:0] open_r,
    output logic rcv_on_r,
    output logic int_clk_on_r,
    output logic bad_cmd_r
);
    localparam int PW = 6 + BA_W + ROW_W;

    logic [PW-1:0] s1_r;
    logic [PW-1:0] s2_r;
    logic ck_d_r;
    logic [WT_W-1:0] tmr_r;
    logic mr_set_r;
    logic emr_set_r;
    logic [NBANK-1:0] open_nxt;

    // pins pass two flops; all fields share the delay so they stay aligned
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            ck_d_r <= 1'b0;
        end else begin
            s1_r <= {bus.ck, bus.cke, bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n,
                     bus.ba, bus.addr};
            s2_r <= s1_r;
            ck_d_r <= s2_r[PW-1];
        end
    end

    wire ck_s = s2_r[PW-1];
    wire cke_s = s2_r[PW-2];
    wire [3:0] cmd_s = s2_r[PW-3 -: 4];
    wire [BA_W-1:0] ba_s = s2_r[ROW_W +: BA_W];
    wire [ROW_W-1:0] addr_s = s2_r[ROW_W-1:0];
    wire rise = ck_s & ~ck_d_r;
    wire awake = (state_r == DS_IDLE) || (state_r == DS_ACTIVE);
    // receivers ignored unless awake with cke high
    wire take = rise && cke_s && awake;
    wire enter_lp = rise && !cke_s && awake;
    // refresh decoded from the sampled pin combination
    wire is_ref = take && (cmd_s == CMD_REF);
    // cke low with refresh code means self refresh
    wire is_sref = enter_lp && (cmd_s == CMD_REF);
    wire is_mrs = take && (cmd_s == CMD_MRS);

    // open row tracking from activate, precharge and auto precharge
    always_comb begin
        open_nxt = open_r;
        if (take) begin
            unique case (cmd_s)
                CMD_ACT: open_nxt[ba_s] = 1'b1;
                CMD_PRE: begin
                    if (addr_s[AP_BIT]) begin
                        open_nxt = '0;
                    end else begin
                        open_nxt[ba_s] = 1'b0;
                    end
                end
                CMD_WR, CMD_RD: begin
                    if (addr_s[AP_BIT]) begin
                        open_nxt[ba_s] = 1'b0;
                    end
                end
                default: open_nxt = open_r;
            endcase
        end
    end

    // bank state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            open_r <= '0;
        end else if (state_r == DS_AREF) begin
            open_r <= '0;
        end else begin
            open_r <= open_nxt;
        end
    end

    // operating state
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= DS_IDLE;
        end else begin
            unique case (state_r)
                DS_IDLE, DS_ACTIVE: begin
                    if (is_sref) begin
                        state_r <= DS_SREF;
                    end else if (enter_lp) begin
                        state_r <= DS_PDN;
                    end else if (is_ref) begin
                        state_r <= DS_AREF;
                    end else begin
                        state_r <= (|open_nxt) ? DS_ACTIVE : DS_IDLE;
                    end
                end
                DS_AREF: begin
                    if (tmr_r == '0) begin
                        state_r <= DS_IDLE;
                    end
                end
                // clock may be stopped, so exit follows cke level alone
                DS_SREF: begin
                    if (cke_s) begin
                        state_r <= DS_IDLE;
                    end
                end
                DS_PDN: begin
                    // cke high at a clock edge leaves power-down
                    if (rise && cke_s) begin
                        state_r <= (|open_r) ? DS_ACTIVE : DS_IDLE;
                    end
                end
                default: state_r <= DS_IDLE;
            endcase
        end
    end

    // row address comes from the internal counter, pins ignored
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tmr_r <= '0;
            ref_row_r <= '0;
        end else if (is_ref) begin
            tmr_r <= cyc(RFC_CYC);
            ref_row_r <= ref_row_r + 1'b1;
        end else if (state_r == DS_SREF) begin
            // self refresh paces itself off its own timer
            if (tmr_r == '0) begin
                tmr_r <= cyc(REFI_CYC);
                ref_row_r <= ref_row_r + 1'b1;
            end else begin
                tmr_r <= tmr_r - 1'b1;
            end
        end else if (tmr_r != '0) begin
            tmr_r <= tmr_r - 1'b1;
        end
    end

    // mode registers reset to zero and only load when written
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_r <= '0;
            emode_r <= '0;
            mr_set_r <= 1'b0;
            emr_set_r <= 1'b0;
            modes_set_r <= 1'b0;
        end else begin
            if (is_mrs && ba_s == BA_MR) begin
                mode_r <= addr_s;
                mr_set_r <= 1'b1;
            end
            if (is_mrs && ba_s == BA_EMR) begin
                emode_r <= addr_s;
                emr_set_r <= 1'b1;
            end
            modes_set_r <= mr_set_r & emr_set_r;
        end
    end

    // sticky misuse flag: refresh or mode set with rows open, or busy command
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bad_cmd_r <= 1'b0;
        end else if (((is_ref || is_sref || is_mrs) && |open_r)
                     || (rise && cke_s && state_r == DS_AREF && cmd_s != CMD_NOP
                         && !cmd_s[3])) begin
            bad_cmd_r <= 1'b1;
        end
    end

    // internal clock gated in self refresh; receivers off when asleep
    always_ff @(posedge clk) begin
        if (!resetn) begin
            int_clk_on_r <= 1'b1;
            rcv_on_r <= 1'b1;
        end else begin
            int_clk_on_r <= (state_r != DS_SREF);
            rcv_on_r <= (state_r != DS_SREF) && (state_r != DS_PDN);
        end
    end
endmodule

// *** lpr_ctrl.sv ***
// controller end: init sequence, refresh pacing, low-power and clock stop
`timescale 1ns/100ps
// Function
// - refresh is cs, ras, cas low, we high
// - precharge all banks before refreshing
// - memory uses internal refresh row counter
// - refresh leaves all banks idle
// - wait refresh cycle before next command
// - self refresh is refresh code, cke low
// - hold cke low through self refresh
// - clock may stop one cycle after entry
// - clock running, nop, before cke rises
// - stay in self refresh refresh-cycle time
// - enter self refresh only when idle
// - cke low sleeps, high wakes memory
// - idle before power-down, exit delay before activate
// - leave power-down before refresh falls due; here left only once due_r is already set
// - power-down lasts at least cke minimum
// - stop clock low only when settled
// - restart clock, one nop before access
// - hold nop, cke high, two hundred microseconds
// - precharge, refreshes, mode set, extended set
// - program both mode registers, banks idle
// - precharge time after write auto precharge
module lpr_ctrl import lpr_pkg::*; #(
    parameter int INIT_CYC_P = INIT_CYC,
    parameter int NUM_INIT_REF = 2
) (
    input wire logic clk,
    input wire logic resetn,
    lpr_if.ctrl bus,
    input wire logic [ROW_W-1:0] mode_val,
    input wire logic [ROW_W-1:0] emode_val,
    input wire logic op_valid,
    input wire lpr_op_t op_kind,
    input wire logic [BA_W-1:0] op_bank,
    input wire logic [ROW_W-1:0] op_row,
    output logic op_ack_r,
    input wire logic sref_req,
    input wire logic pdn_req,
    input wire logic cstop_req,
    output logic init_done_r,
    output lpr_ctl_st_t st_r,
    output logic ck_on_r
);
    // refuse settings the counters cannot hold
    if (INIT_CYC_P < 1 || INIT_CYC_P >= (1 << WT_W) || NUM_INIT_REF < 2
        || NUM_INIT_REF > 15) begin : g_chk
        $error("lpr_ctrl: unsupported init parameters");
    end

    logic ck_r;
    logic ckn_r;
    logic cke_r;
    logic [3:0] cmd_r;
    logic [BA_W-1:0] ba_r;
    logic [ROW_W-1:0] addr_r;
    logic [WT_W-1:0] wt_r;
    logic [3:0] nref_r;
    logic [NBANK-1:0] open_r;
    logic [WT_W-1:0] refi_r;
    logic due_r;
    logic ref_go_r;

    assign bus.ck = ck_r;
    assign bus.ck_n = ckn_r;
    assign bus.cke = cke_r;
    assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = cmd_r;
    assign bus.ba = ba_r;
    assign bus.addr = addr_r;

    // a slot is the cycle before the falling edge: pins change mid-period
    wire slot = ck_on_r && ck_r;
    wire ready = slot && (wt_r == '0);
    wire any_open = |open_r;

    // a stopping clock always parks low, with ck_n high
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ck_r <= 1'b0;
            ckn_r <= 1'b1;
        end else if (ck_on_r || ck_r) begin
            ck_r <= ~ck_r;
            ckn_r <= ck_r;
        end
    end

    // interval counter runs on in power-down too
    always_ff @(posedge clk) begin
        if (!resetn) begin
            refi_r <= cyc(REFI_CYC);
            due_r <= 1'b0;
        end else begin
            if (ref_go_r) begin
                refi_r <= cyc(REFI_CYC);
            end else if (refi_r != '0) begin
                refi_r <= refi_r - 1'b1;
            end
            // the clearing refresh also reloads the interval, so a zero count then is no new due
            due_r <= (refi_r == '0 && !ref_go_r) || (due_r && !ref_go_r);
        end
    end

    // command sequencing, wait timer and bank bookkeeping
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_r <= CS_PWR;
            ck_on_r <= 1'b1;
            cke_r <= 1'b1;
            cmd_r <= CMD_NOP;
            ba_r <= '0;
            addr_r <= '0;
            wt_r <= cyc(INIT_CYC_P);
            nref_r <= '0;
            open_r <= '0;
            init_done_r <= 1'b0;
            op_ack_r <= 1'b0;
            ref_go_r <= 1'b0;
        end else begin
            op_ack_r <= 1'b0;
            ref_go_r <= 1'b0;
            if (wt_r != '0) begin
                wt_r <= wt_r - 1'b1;
            end
            // every command lasts one clock period, then nop
            if (slot) begin
                cmd_r <= CMD_NOP;
            end
            unique case (st_r)
                // nop and stable clock until the power-up wait ends
                CS_PWR: begin
                    if (ready) begin
                        st_r <= CS_IPRE;
                    end
                end
                CS_IPRE: begin
                    if (ready) begin
                        cmd_r <= CMD_PRE;
                        addr_r <= ROW_W'(1 << AP_BIT);
                        wt_r <= cyc(RP_CYC);
                        st_r <= CS_IREF;
                    end
                end
                // two or more refreshes, each tRFC apart
                CS_IREF: begin
                    if (ready) begin
                        cmd_r <= CMD_REF;
                        wt_r <= cyc(RFC_CYC);
                        nref_r <= nref_r + 1'b1;
                        if (nref_r == 4'(NUM_INIT_REF - 1)) begin
                            st_r <= CS_IMRS;
                        end
                    end
                end
                // mode register written while all banks idle
                CS_IMRS: begin
                    if (ready) begin
                        cmd_r <= CMD_MRS;
                        ba_r <= BA_MR;
                        addr_r <= mode_val;
                        wt_r <= cyc(MRD_CYC);
                        st_r <= CS_IEMRS;
                    end
                end
                // extended mode register after the normal one
                CS_IEMRS: begin
                    if (ready) begin
                        cmd_r <= CMD_MRS;
                        ba_r <= BA_EMR;
                        addr_r <= emode_val;
                        wt_r <= cyc(MRD_CYC);
                        ref_go_r <= 1'b1;
                        init_done_r <= 1'b1;
                        st_r <= CS_IDLE;
                    end
                end
                CS_IDLE: begin
                    if (!ready) begin
                        st_r <= CS_IDLE;
                    end else if (due_r && any_open) begin
                        // close all rows, wait tRP, then refresh
                        cmd_r <= CMD_PRE;
                        addr_r <= ROW_W'(1 << AP_BIT);
                        open_r <= '0;
                        wt_r <= cyc(RP_CYC);
                    end else if (due_r) begin
                        cmd_r <= CMD_REF;
                        ref_go_r <= 1'b1;
                        // no activate or refresh before tRFC
                        wt_r <= cyc(RFC_CYC);
                    end else if (sref_req && !any_open) begin
                        // self refresh only from all idle
                        cmd_r <= CMD_REF;
                        cke_r <= 1'b0;
                        wt_r <= cyc(RFC_CYC);
                        st_r <= CS_SREF;
                    end else if (pdn_req && !any_open) begin
                        cke_r <= 1'b0;
                        wt_r <= cyc(CKE_CYC);
                        st_r <= CS_PDN;
                    end else if (op_valid) begin
                        op_ack_r <= 1'b1;
                        ba_r <= op_bank;
                        unique case (op_kind)
                            OP_ACT: begin
                                cmd_r <= CMD_ACT;
                                addr_r <= op_row;
                                open_r[op_bank] <= 1'b1;
                                wt_r <= cyc(RCD_CYC);
                            end
                            OP_PRE: begin
                                cmd_r <= CMD_PRE;
                                addr_r <= ROW_W'(1 << AP_BIT);
                                open_r <= '0;
                                wt_r <= cyc(RP_CYC);
                            end
                            OP_WRAP: begin
                                cmd_r <= CMD_WR;
                                addr_r <= ROW_W'(1 << AP_BIT);
                                open_r[op_bank] <= 1'b0;
                                // write recovery plus tRP before next activate
                                wt_r <= cyc(WR_CYC + RP_CYC);
                            end
                            default: begin
                                cmd_r <= CMD_NOP;
                                op_ack_r <= 1'b0;
                            end
                        endcase
                    end else if (cstop_req) begin
                        // timings met (wt zero), cke high, clock parks low
                        ck_on_r <= 1'b0;
                        st_r <= CS_CSTOP;
                    end
                end
                // cke stays low for the whole stay
                CS_SREF: begin
                    if (slot) begin
                        // stop the clock one period after entry
                        ck_on_r <= 1'b0;
                    end else if (!ck_on_r && !ck_r && !sref_req && wt_r == '0) begin
                        ck_on_r <= 1'b1;
                        wt_r <= cyc(XSR_CYC);
                        st_r <= CS_SRX;
                    end
                end
                // running clock and nop until cke goes high
                CS_SRX: begin
                    if (ready) begin
                        cke_r <= 1'b1;
                        wt_r <= cyc(XSR_CYC);
                        // memory refreshed itself; restart the interval
                        ref_go_r <= 1'b1;
                        st_r <= CS_IDLE;
                    end
                end
                CS_PDN: begin
                    // wake early when refresh falls due
                    if (ready && (!pdn_req || due_r)) begin
                        cke_r <= 1'b1;
                        wt_r <= cyc(PDEX_CYC);
                        st_r <= CS_IDLE;
                    end
                end
                CS_CSTOP: begin
                    if (!ck_r && (!cstop_req || due_r)) begin
                        ck_on_r <= 1'b1;
                        st_r <= CS_CSX;
                    end
                end
                // first slot after restart carries only a nop
                CS_CSX: begin
                    if (slot) begin
                        st_r <= CS_IDLE;
                    end
                end
                default: st_r <= CS_IDLE;
            endcase
        end
    end
endmodule

// *** lpr_link_checker.sv ***
// assertions on the command link between controller and memory
`timescale 1ns/100ps
module lpr_link_checker import lpr_pkg::*; #(
    parameter int INIT_P = 20
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ck,
    input wire logic ck_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [BA_W-1:0] ba,
    input wire logic [ROW_W-1:0] addr
);
    logic [3:0] cmd;
    logic [3:0] prev_r;
    logic [15:0] cyc_r;
    logic [15:0] rg_r;
    logic [2:0] nc_r;
    logic st;
    // a new command is a non-nop code that differs from the last cycle
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign st = !cs_n && cmd != CMD_NOP && cmd != prev_r;
    // counters saturate so that long idle spells never wrap round
    always_ff @(posedge clk) begin
        if (!resetn) begin
            prev_r <= CMD_NOP;
            cyc_r <= 16'h0;
            rg_r <= 16'hffff;
            nc_r <= 3'h0;
        end else begin
            prev_r <= cmd;
            cyc_r <= (cyc_r == 16'hffff) ? cyc_r : cyc_r + 16'h1;
            rg_r <= (st && cmd == CMD_REF) ? 16'h0 : ((rg_r == 16'hffff) ? rg_r : rg_r + 16'h1);
            nc_r <= (st && nc_r != 3'h7) ? nc_r + 3'h1 : nc_r;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_init_nop: assert property (cyc_r < INIT_P |-> cmd == CMD_NOP && cke)
        else $error("power-up wait broken");
    chk_init_pre: assert property (st && nc_r == 3'h0 |-> cmd == CMD_PRE && addr[AP_BIT])
        else $error("first command not precharge all");
    chk_init_ref: assert property (st && nc_r inside {3'h1, 3'h2} |-> cmd == CMD_REF && cke)
        else $error("init refresh missing");
    chk_init_modes: assert property (st && nc_r inside {3'h3, 3'h4}
        |-> cmd == CMD_MRS && ba == ((nc_r == 3'h3) ? BA_MR : BA_EMR))
        else $error("mode register order wrong");
    chk_rfc_space: assert property (st && (cmd == CMD_REF || cmd == CMD_ACT)
        |-> rg_r >= RFC_CYC - 1)
        else $error("refresh cycle time cut short");
    chk_sref_hold: assert property ((!cke && cmd == CMD_REF) |=> (!cke) [*8])
        else $error("self refresh left too soon");
    chk_pdn_min: assert property ($fell(cke) |-> (!cke) [*3])
        else $error("power-down too short");
    chk_cke_rise: assert property ($rose(cke) |-> (cs_n || cmd == CMD_NOP) && ck != $past(ck))
        else $error("wake without nop or clock");
    chk_stop_low: assert property ($stable(ck) |-> !ck)
        else $error("clock stopped high");
    chk_ckn_inverse: assert property (ck_n == !ck)
        else $error("clock pair not inverse");
    chk_restart_nop: assert property (ck && !$past(ck) && !$past(ck, 2)
        |-> (cs_n || cmd == CMD_NOP))
        else $error("access on first edge after restart");
endmodule

// *** sdram_refresh_powerdown_ctrl_tb.sv ***
// self-checking bench for the refresh and power-down link
`timescale 1ns/100ps
module sdram_refresh_powerdown_ctrl_tb import lpr_pkg::*;;
    localparam int INIT_T = 20;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic op_valid = 1'b0, sref_req = 1'b0, pdn_req = 1'b0, cstop_req = 1'b0;
    logic [ROW_W-1:0] mode_val = '0, emode_val = '0, op_row = '0, ref_row_r, mode_r, emode_r;
    lpr_op_t op_kind = OP_ACT;
    logic [BA_W-1:0] op_bank = '0;
    logic op_ack_r, init_done_r, ck_on_r, modes_set_r, rcv_on_r, int_clk_on_r, bad_cmd_r;
    lpr_ctl_st_t st_r;
    lpr_dev_st_t state_r;
    logic [NBANK-1:0] open_r;
    logic [3:0] cmd, prev;
    int failures = 0, n_tests = 0, cyc = 0, ref_cnt = 0, exp_open = 0, seed = 32'h600f7119;
    lpr_if bus ();
    lpr_ctrl #(.INIT_CYC_P(INIT_T), .NUM_INIT_REF(2)) i_lpr_ctrl (.clk(clk), .resetn(resetn),
        .bus(bus), .mode_val(mode_val), .emode_val(emode_val), .op_valid(op_valid),
        .op_kind(op_kind), .op_bank(op_bank), .op_row(op_row), .op_ack_r(op_ack_r),
        .sref_req(sref_req), .pdn_req(pdn_req), .cstop_req(cstop_req),
        .init_done_r(init_done_r), .st_r(st_r), .ck_on_r(ck_on_r));
    lpr_mem i_lpr_mem (.clk(clk), .resetn(resetn), .bus(bus), .state_r(state_r),
        .ref_row_r(ref_row_r), .mode_r(mode_r), .emode_r(emode_r), .modes_set_r(modes_set_r),
        .open_r(open_r), .rcv_on_r(rcv_on_r), .int_clk_on_r(int_clk_on_r), .bad_cmd_r(bad_cmd_r));
    lpr_link_checker #(.INIT_P(INIT_T)) i_lpr_link_checker (.clk(clk), .resetn(resetn),
        .ck(bus.ck), .ck_n(bus.ck_n), .cke(bus.cke), .cs_n(bus.cs_n), .ras_n(bus.ras_n),
        .cas_n(bus.cas_n), .we_n(bus.we_n), .ba(bus.ba), .addr(bus.addr));
    initial forever #2 clk = ~clk;
    // model: count refreshes seen on the wire; also the hang limit
    assign cmd = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
    always @(posedge clk) begin
        prev <= cmd;
        cyc <= cyc + 1;
        if (cmd == CMD_REF && prev != CMD_REF && bus.cke)
            ref_cnt <= ref_cnt + 1;
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_st(input lpr_ctl_st_t s);
        for (int i = 0; i < 4000 && st_r !== s; i++)
            @(posedge clk);
        repeat (8) @(posedge clk);
    endtask
    // hold the request until the ack edge, then update the open-bank model
    task automatic do_op(input lpr_op_t k, input int b);
        op_kind <= k;
        op_bank <= b[BA_W-1:0];
        op_row <= ROW_W'($random(seed));
        op_valid <= 1'b1;
        for (int i = 0; i < 300 && op_ack_r !== 1'b1; i++)
            @(posedge clk);
        op_valid <= 1'b0;
        if (k == OP_ACT)
            exp_open = exp_open | (1 << b);
        else
            exp_open = (k == OP_PRE) ? 0 : exp_open & ~(1 << b);
        repeat (24) @(posedge clk);
        check("open_r", open_r, exp_open);
    endtask
    task automatic close_out();
        if (failures == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        int b;
        int n0;
        b = $random(seed) & 3;
        @(posedge clk);
        mode_val <= ROW_W'($random(seed));
        emode_val <= ROW_W'($random(seed));
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        wait_st(CS_IDLE);
        check("init_done", init_done_r, 1);
        check("modes_set", modes_set_r, 1);
        check("mode_r", mode_r, mode_val);
        check("emode_r", emode_r, emode_val);
        check("init refs", ref_cnt, 2);
        do_op(OP_ACT, b);
        do_op(OP_WRAP, b);
        do_op(OP_ACT, b);
        do_op(OP_ACT, (b + 1) & 3);
        do_op(OP_PRE, b);
        n0 = ref_cnt;
        repeat (2 * REFI_CYC + 200) @(posedge clk);
        check("paced", ref_cnt >= n0 + 2, 1);
        check("ref_row", ref_row_r, ref_cnt);
        check("idle", state_r, DS_IDLE);
        sref_req <= 1'b1;
        wait_st(CS_SREF);
        repeat (30) @(posedge clk);
        check("sref", state_r, DS_SREF);
        check("int clk", int_clk_on_r, 0);
        sref_req <= 1'b0;
        wait_st(CS_IDLE);
        check("sref exit", state_r, DS_IDLE);
        n0 = ref_cnt;
        pdn_req <= 1'b1;
        wait_st(CS_PDN);
        check("pdn", state_r, DS_PDN);
        check("rcv off", rcv_on_r, 0);
        repeat (REFI_CYC + 300) @(posedge clk);
        check("pdn wake", ref_cnt > n0, 1);
        pdn_req <= 1'b0;
        wait_st(CS_IDLE);
        check("rcv on", rcv_on_r, 1);
        cstop_req <= 1'b1;
        wait_st(CS_CSTOP);
        check("ck_on", ck_on_r, 0);
        check("ck low", bus.ck, 0);
        cstop_req <= 1'b0;
        wait_st(CS_IDLE);
        do_op(OP_ACT, b);
        do_op(OP_PRE, b);
        check("bad_cmd", bad_cmd_r, 0);
        close_out();
    end
endmodule
